// *** rtl/ufe_pkg.sv ***
`default_nettype none
package ufe_pkg;
  // Number of event flags
  localparam int NFLAG = 7;

  // Register offsets
  localparam logic [7:0] OFS_RESET   = 8'h00;
  localparam logic [7:0] OFS_IFM     = 8'h04;
  localparam logic [7:0] OFS_ADDR    = 8'h08;
  localparam logic [7:0] OFS_FUNC    = 8'h0C;
  localparam logic [7:0] OFS_OTGC    = 8'h10;
  localparam logic [7:0] OFS_OTGF    = 8'h14;
  localparam logic [7:0] OFS_SER     = 8'h18;
  localparam logic [7:0] OFS_FLAGS   = 8'h1C;
  localparam logic [7:0] OFS_STICKY  = 8'h20;
  localparam logic [7:0] OFS_MASKS   = 8'h24;
  localparam logic [7:0] OFS_FRAME   = 8'h28;
  localparam logic [7:0] OFS_PID     = 8'h2C;
  localparam logic [7:0] OFS_ENDP    = 8'h30;
  localparam logic [7:0] OFS_EPMATCH = 8'h34;
  localparam logic [7:0] OFS_OTGMASK = 8'h38;

  // Values after reset and writable-bit masks
  localparam logic [4:0] FUNC_INIT  = 5'h07;
  localparam logic [3:0] SER_INIT   = 4'h2;
  localparam logic [7:0] IFM_WMASK  = 8'hF7;
  localparam logic [7:0] OTGC_WMASK = 8'hDF;

  // Field positions
  localparam int IFM_LINEDEC = 2;
  localparam int EP_VALID    = 4;
  localparam int F_TOKEN     = 6;
  localparam int F_SE0       = 5;
  localparam int F_K         = 4;
  localparam int F_J         = 3;
  localparam int F_CRC16     = 2;
  localparam int F_RXACT     = 1;
  localparam int F_RXERR     = 0;

  // Line state codes
  localparam logic [1:0] LS_SE0 = 2'h0;
  localparam logic [1:0] LS_J   = 2'h1;
  localparam logic [1:0] LS_K   = 2'h2;

  // State of the front end apart from the flag bank and synchroniser stages
  typedef struct packed {
    logic [7:0]  ifm;
    logic [6:0]  dev_addr;
    logic [4:0]  func;
    logic [7:0]  otg;
    logic [3:0]  ser;
    logic [6:0]  sticky;
    logic [31:0] masks;
    logic [10:0] frame;
    logic [3:0]  pid;
    logic [4:0]  endp;
    logic [15:0] ep_match;
    logic [31:0] otg_mask;
    logic        accept;
    logic [1:0]  ls_prev;
    logic        rxact_prev;
    logic        rxerr_prev;
    logic        rx_valid;
    logic [3:0]  rx_pid;
    logic [4:0]  rx_endp;
    logic [3:0]  evt;
    logic [31:0] rdata;
    logic        rvalid;
  } ufe_state_t;

  function automatic ufe_state_t ufe_init();
    ufe_init      = '0;
    ufe_init.func = FUNC_INIT;
    ufe_init.ser  = SER_INIT;
  endfunction
endpackage
`default_nettype wire

// *** rtl/ufe_flag_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface ufe_flag_if;
  import ufe_pkg::*;
  logic [NFLAG-1:0] upd;
  logic [NFLAG-1:0] val;
  logic [NFLAG-1:0] wclr;
  logic [NFLAG-1:0] sticky;
  logic [NFLAG-1:0] flags;
  logic             new_pkt;
  logic             fe_clear;
  modport bank(input upd, val, wclr, sticky, new_pkt, fe_clear, output flags);
  modport ctrl(output upd, val, wclr, sticky, new_pkt, fe_clear, input flags);
endinterface
`default_nettype wire

// *** rtl/ufe_sync2.sv ***
`timescale 1ns/1ps
`default_nettype none
module ufe_sync2 #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ufe_sync_t;
  ufe_sync_t st_r;
  ufe_sync_t st_nxt;

  // First stage feeds only the second
  always_comb begin
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.s2;
endmodule
`default_nettype wire

// *** rtl/ufe_flag_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
module ufe_flag_bank
  import ufe_pkg::*;
(
  input  wire logic mclk,
  input  wire logic reset,
  ufe_flag_if.bank  fif
);
  typedef struct packed {
    logic [NFLAG-1:0] flags;
  } ufe_bank_t;
  ufe_bank_t st_r;
  ufe_bank_t st_nxt;

  // Per-flag update; a set in a write-one or new-packet clearing cycle wins, but front-end clear wins over all
  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < NFLAG; i++) begin
      if (fif.sticky[i]) begin
        if (fif.upd[i] && fif.val[i]) begin
          st_nxt.flags[i] = 1'b1;
        end else if (fif.wclr[i]) begin
          st_nxt.flags[i] = 1'b0;
        end
      end else if (fif.upd[i]) begin
        st_nxt.flags[i] = fif.val[i];
      end else if (fif.wclr[i] || fif.new_pkt) begin
        st_nxt.flags[i] = 1'b0;
      end
    end
    if (fif.fe_clear) begin
      st_nxt.flags = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign fif.flags = st_r.flags;

  a_sticky_hold: assert property (@(posedge mclk) disable iff (reset)
    (fif.sticky[F_RXERR] && fif.flags[F_RXERR] && !fif.wclr[F_RXERR] && !fif.fe_clear)
    |=> fif.flags[F_RXERR])
    else $error("sticky flag lost without a clear");
  a_plain_clear: assert property (@(posedge mclk) disable iff (reset)
    (!fif.sticky[F_CRC16] && fif.new_pkt && !fif.upd[F_CRC16])
    |=> !fif.flags[F_CRC16])
    else $error("plain flag not cleared on new packet");
endmodule
`default_nettype wire

// *** rtl/ufe_usb_front_end.sv ***
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Hold 7-bit address; pass only matching packets
// - Function register drives opmode, termselect, xcvrselect
// - On-the-go bits 7,6 drive VBUS select, drive
// - On-the-go bits 4..0 drive charge and pull controls
// - On-the-go flags mirror transceiver status inputs
// - Serial register shows receive lines, bits 6..4
// - Serial bits drive SE0, data, enable_n, serial mode
// - Flag 6 set on good addressed token
// - Flags 5,4,3 set on SE0, K, J
// - Flag 2 set on data CRC16 failure
// - Flags 1,0 follow receive-active and receive-error
// - Plain flags clear per packet, track source
// - Stickiness bit holds flag until written one
// - Four masks OR selected flags onto ports
// - Writable 11-bit frame counter, reset zero
// - Capture last packet identifier, reset zero
// - Record last endpoint with valid bit
// - Matched endpoint delivered ORed with 0x10
// - Any write to reset register restores initial state
// - Line flags update only when decoder enabled
module ufe_usb_front_end
  import ufe_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             reg_rvalid,
  input  wire logic [1:0]  utmi_linestate,
  input  wire logic        utmi_rxactive,
  input  wire logic        utmi_rxerror,
  input  wire logic [5:0]  utmi_otg_status,
  input  wire logic [2:0]  fs_rx_lines,
  input  wire logic        pkt_valid,
  input  wire logic        pkt_is_token,
  input  wire logic        pkt_is_sof,
  input  wire logic        pkt_is_data,
  input  wire logic [3:0]  pkt_pid,
  input  wire logic [10:0] pkt_field,
  input  wire logic        pkt_crc5_ok,
  input  wire logic        pkt_pid_ok,
  input  wire logic        pkt_crc16_ok,
  output logic             rx_valid,
  output logic      [3:0]  rx_pid,
  output logic      [4:0]  rx_endp,
  output logic      [2:0]  utmi_opmode,
  output logic             utmi_termselect,
  output logic             utmi_xcvrselect,
  output logic             ext_vbus_ind_sel,
  output logic             ext_vbus_drive,
  output logic             utmi_chrgvbus,
  output logic             utmi_dischrgvbus,
  output logic             utmi_dmpulldown,
  output logic             utmi_dppulldown,
  output logic             utmi_idpullup,
  output logic             fs_txse0,
  output logic             fs_txdata,
  output logic             fs_txenable_n,
  output logic             fs_serial_mode,
  output logic             event_port_n,
  output logic             event_port_o,
  output logic             event_port_p,
  output logic             event_port_q
);
  ufe_state_t  st_r;
  ufe_state_t  st_nxt;
  logic [12:0] sync_q;
  logic [1:0]  ls;
  logic        rxact;
  logic        rxerr;
  logic [5:0]  otg_in;
  logic [2:0]  rx_lines;
  logic        soft_rst;
  logic        tok_seen;
  logic        tok_ok;
  logic        sof_ok;
  logic        crc_bad;
  logic        ls_upd;
  logic [6:0]  tok_addr;
  logic [3:0]  tok_ep;
  logic [7:0]  flags8;

  ufe_flag_if fif ();

  // Transceiver pins come from outside this clock
  ufe_sync2 #(
    .W(13)
  ) u_sync (
    .mclk  (mclk),
    .reset (reset),
    .din   ({utmi_linestate, utmi_rxactive, utmi_rxerror,
             utmi_otg_status, fs_rx_lines}),
    .dout  (sync_q)
  );

  assign ls       = sync_q[12:11];
  assign rxact    = sync_q[10];
  assign rxerr    = sync_q[9];
  assign otg_in   = sync_q[8:3];
  assign rx_lines = sync_q[2:0];

  ufe_flag_bank u_flags (
    .mclk  (mclk),
    .reset (reset),
    .fif   (fif.bank)
  );

  // Token field splits into address and endpoint
  assign tok_addr = pkt_field[6:0];
  assign tok_ep   = pkt_field[10:7];
  assign soft_rst = reg_wr && (reg_addr == OFS_RESET);
  assign tok_seen = pkt_valid && pkt_is_token && !pkt_is_sof;
  assign tok_ok   = tok_seen && pkt_crc5_ok && pkt_pid_ok
                    && (tok_addr == st_r.dev_addr);
  assign sof_ok   = pkt_valid && pkt_is_sof && pkt_crc5_ok && pkt_pid_ok;
  assign crc_bad  = pkt_valid && pkt_is_data && !pkt_crc16_ok;
  // Decoder gate stops line flags while disabled
  assign ls_upd   = (ls != st_r.ls_prev) && st_r.ifm[IFM_LINEDEC];

  // Flag sources; event strobes carry value one
  assign fif.upd[F_TOKEN] = tok_ok;
  assign fif.val[F_TOKEN] = 1'b1;
  assign fif.upd[F_SE0]   = ls_upd;
  assign fif.val[F_SE0]   = (ls == LS_SE0);
  assign fif.upd[F_K]     = ls_upd;
  assign fif.val[F_K]     = (ls == LS_K);
  assign fif.upd[F_J]     = ls_upd;
  assign fif.val[F_J]     = (ls == LS_J);
  assign fif.upd[F_CRC16] = crc_bad;
  assign fif.val[F_CRC16] = 1'b1;
  assign fif.upd[F_RXACT] = (rxact != st_r.rxact_prev);
  assign fif.val[F_RXACT] = rxact;
  assign fif.upd[F_RXERR] = (rxerr != st_r.rxerr_prev);
  assign fif.val[F_RXERR] = rxerr;

  // Software write of one clears a flag
  assign fif.wclr     = (reg_wr && reg_addr == OFS_FLAGS) ? reg_wdata[6:0] : '0;
  assign fif.sticky   = st_r.sticky;
  assign fif.new_pkt  = rxact && !st_r.rxact_prev;
  assign fif.fe_clear = soft_rst;
  assign flags8       = {1'b0, fif.flags};

  // Next state: packets, register writes, read data
  always_comb begin
    st_nxt            = st_r;
    st_nxt.rx_valid   = 1'b0;
    st_nxt.rvalid     = reg_rd;
    st_nxt.ls_prev    = ls;
    st_nxt.rxact_prev = rxact;
    st_nxt.rxerr_prev = rxerr;

    // Address filter opens on a good addressed token
    if (tok_ok) begin
      st_nxt.accept   = 1'b1;
      st_nxt.endp     = {1'b1, tok_ep};
      st_nxt.rx_valid = 1'b1;
      st_nxt.rx_pid   = pkt_pid;
      st_nxt.rx_endp  = {st_r.ep_match[tok_ep], tok_ep};
    end else if (tok_seen) begin
      st_nxt.accept = 1'b0;
    end else if (pkt_valid && !pkt_is_sof && st_r.accept) begin
      // Data and handshakes follow the last accepted token
      st_nxt.rx_valid = 1'b1;
      st_nxt.rx_pid   = pkt_pid;
    end
    if (pkt_valid && pkt_pid_ok) begin
      st_nxt.pid = pkt_pid;
    end
    if (sof_ok) begin
      st_nxt.frame = pkt_field;
    end

    // Event ports one cycle behind the flags
    st_nxt.evt[0] = |(st_r.masks[7:0] & flags8);
    st_nxt.evt[1] = |(st_r.masks[15:8] & flags8);
    st_nxt.evt[2] = |(st_r.masks[23:16] & flags8);
    st_nxt.evt[3] = |(st_r.masks[31:24] & flags8);

    // Register writes; software wins over packet updates
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_IFM:     st_nxt.ifm = reg_wdata[7:0] & IFM_WMASK;
        OFS_ADDR:    st_nxt.dev_addr = reg_wdata[6:0];
        OFS_FUNC:    st_nxt.func = reg_wdata[4:0];
        OFS_OTGC:    st_nxt.otg = reg_wdata[7:0] & OTGC_WMASK;
        OFS_SER:     st_nxt.ser = reg_wdata[3:0];
        OFS_STICKY:  st_nxt.sticky = reg_wdata[6:0];
        OFS_MASKS:   st_nxt.masks = reg_wdata;
        OFS_FRAME:   st_nxt.frame = reg_wdata[10:0];
        OFS_EPMATCH: st_nxt.ep_match = reg_wdata[15:0];
        OFS_OTGMASK: st_nxt.otg_mask = reg_wdata;
        default:     st_nxt.ifm = st_nxt.ifm;
      endcase
    end

    // Read data registered; unmapped and reserved read zero
    st_nxt.rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_IFM:     st_nxt.rdata = {24'h000000, st_r.ifm};
        OFS_ADDR:    st_nxt.rdata = {25'h0000000, st_r.dev_addr};
        OFS_FUNC:    st_nxt.rdata = {27'h0000000, st_r.func};
        OFS_OTGC:    st_nxt.rdata = {24'h000000, st_r.otg};
        OFS_OTGF:    st_nxt.rdata = {26'h0000000, otg_in};
        OFS_SER:     st_nxt.rdata = {25'h0000000, rx_lines, st_r.ser};
        OFS_FLAGS:   st_nxt.rdata = {25'h0000000, fif.flags};
        OFS_STICKY:  st_nxt.rdata = {25'h0000000, st_r.sticky};
        OFS_MASKS:   st_nxt.rdata = st_r.masks;
        OFS_FRAME:   st_nxt.rdata = {21'h000000, st_r.frame};
        OFS_PID:     st_nxt.rdata = {28'h0000000, st_r.pid};
        OFS_ENDP:    st_nxt.rdata = {27'h0000000, st_r.endp};
        OFS_EPMATCH: st_nxt.rdata = {16'h0000, st_r.ep_match};
        OFS_OTGMASK: st_nxt.rdata = st_r.otg_mask;
        default:     st_nxt.rdata = '0;
      endcase
    end

    // Front-end reset write restores every initial value except read valid, which follows reg_rd
    if (soft_rst) begin
      st_nxt        = ufe_init();
      st_nxt.rvalid = reg_rd;
    end
  end

  // Single register for front-end state outside the flag bank and synchroniser
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r <= ufe_init();
    end else begin
      st_r <= st_nxt;
    end
  end

  // Transceiver controls straight from register fields
  assign utmi_opmode      = st_r.func[4:2];
  assign utmi_termselect  = st_r.func[1];
  assign utmi_xcvrselect  = st_r.func[0];
  assign ext_vbus_ind_sel = st_r.otg[7];
  assign ext_vbus_drive   = st_r.otg[6];
  assign utmi_chrgvbus    = st_r.otg[4];
  assign utmi_dischrgvbus = st_r.otg[3];
  assign utmi_dmpulldown  = st_r.otg[2];
  assign utmi_dppulldown  = st_r.otg[1];
  assign utmi_idpullup    = st_r.otg[0];
  assign fs_txse0         = st_r.ser[3];
  assign fs_txdata        = st_r.ser[2];
  assign fs_txenable_n    = st_r.ser[1];
  assign fs_serial_mode   = st_r.ser[0];
  assign event_port_n     = st_r.evt[0];
  assign event_port_o     = st_r.evt[1];
  assign event_port_p     = st_r.evt[2];
  assign event_port_q     = st_r.evt[3];
  assign rx_valid         = st_r.rx_valid;
  assign rx_pid           = st_r.rx_pid;
  assign rx_endp          = st_r.rx_endp;
  assign reg_rdata        = st_r.rdata;
  assign reg_rvalid       = st_r.rvalid;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  a_addr_filter: assert property (
    (tok_seen && tok_addr != st_r.dev_addr && !soft_rst) |=> !rx_valid)
    else $error("token for another address was forwarded");

  a_func_drive: assert property (
    (reg_wr && reg_addr == OFS_FUNC)
    |=> (utmi_opmode == $past(reg_wdata[4:2]) && utmi_xcvrselect == $past(reg_wdata[0])))
    else $error("function outputs do not follow write");

  a_otg_drive: assert property (
    (reg_wr && reg_addr == OFS_OTGC)
    |=> (ext_vbus_drive == $past(reg_wdata[6]) && utmi_chrgvbus == $past(reg_wdata[4])))
    else $error("on-the-go outputs do not follow write");

  a_txen_drive: assert property (
    (reg_wr && reg_addr == OFS_SER) |=> fs_txenable_n == $past(reg_wdata[1]))
    else $error("transmit enable does not follow write");

  a_otg_mirror: assert property (
    (reg_rd && reg_addr == OFS_OTGF && !soft_rst)
    |=> (reg_rvalid && reg_rdata == {26'h0000000, $past(otg_in)}))
    else $error("on-the-go flags read wrong");

  a_token_flag: assert property (
    (tok_ok && !soft_rst) |=> fif.flags[F_TOKEN])
    else $error("token flag not set");

  a_crc_flag: assert property (
    (crc_bad && !soft_rst) |=> fif.flags[F_CRC16])
    else $error("crc flag not set");

  a_port_or: assert property (
    !$past(soft_rst) |-> event_port_n == $past(|(st_r.masks[7:0] & flags8)))
    else $error("event port n does not match masked flags");

  a_frame_load: assert property (
    (sof_ok && !reg_wr) |=> st_r.frame == $past(pkt_field))
    else $error("frame counter not loaded");

  a_endp_tag: assert property (
    (tok_ok && !soft_rst) |=> (rx_valid && rx_endp[4] == st_r.ep_match[rx_endp[3:0]]))
    else $error("endpoint tag wrong");

  a_soft_reset: assert property (
    soft_rst |=> (utmi_opmode == FUNC_INIT[4:2] && st_r.dev_addr == 7'h00 && !fs_txse0))
    else $error("front-end reset did not reinitialise");

  a_line_gate: assert property (
    fif.upd[F_J] |-> st_r.ifm[IFM_LINEDEC])
    else $error("line flag updated while decoder off");

  a_pid_capture: assert property (
    (pkt_valid && pkt_pid_ok && !soft_rst) |=> st_r.pid == $past(pkt_pid))
    else $error("packet identifier not captured");

  a_endp_record: assert property (
    (tok_ok && !soft_rst) |=> st_r.endp == {1'b1, $past(tok_ep)})
    else $error("endpoint not recorded");

  a_rsvd_zero: assert property (
    (reg_rd && reg_addr == OFS_ADDR) |=> reg_rdata[31:7] == 25'h0000000)
    else $error("reserved address bits read nonzero");

  a_rxact_track: assert property (
    (rxact != st_r.rxact_prev && !fif.sticky[F_RXACT] && !soft_rst)
    |=> fif.flags[F_RXACT] == $past(rxact))
    else $error("receive-active flag does not follow input");

  a_se0_track: assert property (
    (ls_upd && !fif.sticky[F_SE0] && !soft_rst) |=> fif.flags[F_SE0] == $past(ls == LS_SE0))
    else $error("line SE0 flag does not follow line state");

  c_forward: cover property (tok_ok ##1 rx_valid && rx_endp[4]);
  c_sticky: cover property (fif.sticky[F_RXERR] && fif.flags[F_RXERR] ##1 fif.new_pkt);
  c_port_hi: cover property (event_port_q);
  c_soft: cover property (soft_rst);
endmodule
`default_nettype wire

// *** test/ufe_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Far side: transceiver pins and the packets decoded from the host's traffic
module ufe_host_model
  import ufe_pkg::*;
(
  input  wire logic        mclk,
  output logic      [1:0]  utmi_linestate,
  output logic             utmi_rxactive,
  output logic             utmi_rxerror,
  output logic      [5:0]  utmi_otg_status,
  output logic      [2:0]  fs_rx_lines,
  output logic             pkt_valid,
  output logic             pkt_is_token,
  output logic             pkt_is_sof,
  output logic             pkt_is_data,
  output logic      [3:0]  pkt_pid,
  output logic      [10:0] pkt_field,
  output logic             pkt_crc5_ok,
  output logic             pkt_pid_ok,
  output logic             pkt_crc16_ok
);
  // Idle bus sits in J with no packet
  initial begin
    {utmi_linestate, utmi_rxactive, utmi_rxerror} = {LS_J, 2'h0};
    {utmi_otg_status, fs_rx_lines} = 9'h000;
    {pkt_valid, pkt_is_token, pkt_is_sof, pkt_is_data, pkt_pid} = 8'h00;
    {pkt_field, pkt_crc5_ok, pkt_pid_ok, pkt_crc16_ok} = 14'h0000;
  end

  // Pin levels move away from the sampling edge
  task automatic pins(input logic [1:0] ls, input logic act, input logic err,
                      input logic [5:0] otg, input logic [2:0] fs);
    @(negedge mclk);
    {utmi_linestate, utmi_rxactive, utmi_rxerror, utmi_otg_status, fs_rx_lines} = {ls, act, err, otg, fs};
  endtask

  // One packet for one cycle; stale fields are scrambled, not kept
  task automatic send(input logic [2:0] kind, input logic [3:0] pid,
                      input logic [10:0] fld, input logic [2:0] ok);
    @(negedge mclk);
    {pkt_is_token, pkt_is_sof, pkt_is_data, pkt_pid, pkt_field} = {kind, pid, fld};
    {pkt_crc5_ok, pkt_pid_ok, pkt_crc16_ok} = ok;
    pkt_valid = 1'h1;
    @(negedge mclk);
    pkt_valid = 1'h0;
    {pkt_is_token, pkt_is_sof, pkt_is_data, pkt_pid, pkt_field} = ~{kind, pid, fld};
    {pkt_crc5_ok, pkt_pid_ok, pkt_crc16_ok} = ~ok;
  endtask
endmodule
`default_nettype wire

// *** test/usb_phy_interface_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module usb_phy_interface_regs_tb;
  import ufe_pkg::*;
  logic        mclk = 1'h0;
  logic        reset = 1'h1;
  logic        reg_wr = 1'h0;
  logic        reg_rd = 1'h0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic        reg_rvalid, rx_valid, pkt_valid, pkt_is_token, pkt_is_sof, pkt_is_data;
  logic [3:0]  rx_pid, pkt_pid;
  logic [4:0]  rx_endp;
  logic [2:0]  utmi_opmode, fs_rx_lines;
  logic [1:0]  utmi_linestate;
  logic [5:0]  utmi_otg_status;
  logic [10:0] pkt_field;
  logic        utmi_rxactive, utmi_rxerror, pkt_crc5_ok, pkt_pid_ok, pkt_crc16_ok;
  logic        utmi_termselect, utmi_xcvrselect, ext_vbus_ind_sel, ext_vbus_drive;
  logic        utmi_chrgvbus, utmi_dischrgvbus, utmi_dmpulldown, utmi_dppulldown;
  logic        utmi_idpullup, fs_txse0, fs_txdata, fs_txenable_n, fs_serial_mode;
  logic        event_port_n, event_port_o, event_port_p, event_port_q;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cycles = 0;

  // Pin groups packed into words; function, on-the-go and serial as their register images
  wire logic [31:0] func_pins = {27'h0, utmi_opmode, utmi_termselect, utmi_xcvrselect};
  wire logic [31:0] otg_pins = {24'h0, ext_vbus_ind_sel, ext_vbus_drive, 1'h0, utmi_chrgvbus,
                                utmi_dischrgvbus, utmi_dmpulldown, utmi_dppulldown, utmi_idpullup};
  wire logic [31:0] ser_pins = {28'h0, fs_txse0, fs_txdata, fs_txenable_n, fs_serial_mode};
  wire logic [31:0] rx_seen = {22'h0, rx_valid, rx_pid, rx_endp};
  wire logic [31:0] ports = {28'h0, event_port_q, event_port_p, event_port_o, event_port_n};

  ufe_usb_front_end dut (
    .mclk, .reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
    .utmi_linestate, .utmi_rxactive, .utmi_rxerror, .utmi_otg_status, .fs_rx_lines,
    .pkt_valid, .pkt_is_token, .pkt_is_sof, .pkt_is_data, .pkt_pid, .pkt_field,
    .pkt_crc5_ok, .pkt_pid_ok, .pkt_crc16_ok, .rx_valid, .rx_pid, .rx_endp,
    .utmi_opmode, .utmi_termselect, .utmi_xcvrselect, .ext_vbus_ind_sel, .ext_vbus_drive,
    .utmi_chrgvbus, .utmi_dischrgvbus, .utmi_dmpulldown, .utmi_dppulldown, .utmi_idpullup,
    .fs_txse0, .fs_txdata, .fs_txenable_n, .fs_serial_mode,
    .event_port_n, .event_port_o, .event_port_p, .event_port_q
  );

  ufe_host_model host (
    .mclk, .utmi_linestate, .utmi_rxactive, .utmi_rxerror, .utmi_otg_status, .fs_rx_lines,
    .pkt_valid, .pkt_is_token, .pkt_is_sof, .pkt_is_data, .pkt_pid, .pkt_field,
    .pkt_crc5_ok, .pkt_pid_ok, .pkt_crc16_ok
  );

  always #5 mclk = ~mclk;

  // Cut a hang short; the whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch = n_mismatch + 1;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Whole 32-bit word per access
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge mclk);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'h1};
    @(negedge mclk);
    {reg_wdata, reg_wr} = {~d, 1'h0};
  endtask

  // Answer stands one cycle after the request edge
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(negedge mclk);
    {reg_addr, reg_rd} = {a, 1'h1};
    @(negedge mclk);
    reg_rd = 1'h0;
    check("read valid", {31'h0, reg_rvalid}, 32'h1);
    check(what, reg_rdata, exp);
  endtask

  task automatic t_reset();
    check("func pins", func_pins, 32'h7);
    check("otg pins", otg_pins, 32'h0);
    check("serial pins", ser_pins, 32'h2);
    rdc("address", OFS_ADDR, 32'h0);
    rdc("serial", OFS_SER, 32'h2);
    rdc("masks", OFS_MASKS, 32'h0);
    rdc("frame", OFS_FRAME, 32'h0);
    rdc("pid", OFS_PID, 32'h0);
    rdc("endpoint", OFS_ENDP, 32'h0);
    rdc("ep match", OFS_EPMATCH, 32'h0);
    rdc("otg mask", OFS_OTGMASK, 32'h0);
    $display("t_reset done");
  endtask

  // All ones then all zeros through each control word
  task automatic t_ctrl();
    logic [31:0] v;
    for (int i = 0; i < 2; i++) begin
      v = (i == 0) ? 32'hFFFFFFFF : 32'h0;
      wr(OFS_FUNC, v);
      wr(OFS_OTGC, v);
      wr(OFS_SER, v);
      check("func pins", func_pins, v & 32'h1F);
      check("otg pins", otg_pins, v & 32'hDF);
      check("serial pins", ser_pins, v & 32'hF);
      rdc("func", OFS_FUNC, v & 32'h1F);
      rdc("otg ctl", OFS_OTGC, v & 32'hDF);
      wr(OFS_OTGMASK, v);
      rdc("otg mask", OFS_OTGMASK, v);
    end
    $display("t_ctrl done");
  endtask

  task automatic t_status();
    host.pins(LS_J, 1'h0, 1'h0, 6'h2A, 3'h5);
    cyc(4);
    rdc("otg flags", OFS_OTGF, 32'h2A);
    rdc("serial rx", OFS_SER, 32'h50);
    host.pins(LS_J, 1'h0, 1'h0, 6'h15, 3'h2);
    cyc(4);
    rdc("otg flags", OFS_OTGF, 32'h15);
    rdc("serial rx", OFS_SER, 32'h20);
    $display("t_status done");
  endtask

  task automatic t_filter();
    wr(OFS_ADDR, 32'h5);
    wr(OFS_EPMATCH, 32'h8);
    host.send(3'h4, 4'h9, {4'h3, 7'h05}, 3'h7);
    check("rx token", rx_seen, 32'h333);
    rdc("flags", OFS_FLAGS, 32'h40);
    rdc("endpoint", OFS_ENDP, 32'h13);
    rdc("pid", OFS_PID, 32'h9);
    host.send(3'h1, 4'h3, 11'h000, 3'h6);
    check("rx data", rx_seen, 32'h273);
    rdc("flags", OFS_FLAGS, 32'h44);
    host.send(3'h4, 4'h1, {4'h2, 7'h06}, 3'h7);
    check("rx other addr", {31'h0, rx_valid}, 32'h0);
    host.send(3'h1, 4'hB, 11'h000, 3'h7);
    check("rx data dropped", {31'h0, rx_valid}, 32'h0);
    rdc("pid", OFS_PID, 32'hB);
    host.send(3'h4, 4'h1, {4'h2, 7'h05}, 3'h3);
    check("rx bad crc5", {31'h0, rx_valid}, 32'h0);
    host.send(3'h4, 4'h1, {4'h2, 7'h05}, 3'h7);
    check("rx plain ep", rx_seen, 32'h222);
    rdc("endpoint", OFS_ENDP, 32'h12);
    wr(OFS_FLAGS, 32'h7F);
    rdc("flags", OFS_FLAGS, 32'h0);
    $display("t_filter done");
  endtask

  task automatic t_frame();
    host.send(3'h2, 4'h5, 11'h5A3, 3'h7);
    rdc("frame", OFS_FRAME, 32'h5A3);
    wr(OFS_FRAME, 32'hFFFFFFFF);
    rdc("frame", OFS_FRAME, 32'h7FF);
    $display("t_frame done");
  endtask

  task automatic t_flags();
    logic [1:0] ls [3] = '{LS_SE0, LS_K, LS_J};
    host.pins(LS_K, 1'h0, 1'h0, 6'h15, 3'h2);
    cyc(5);
    rdc("flags off", OFS_FLAGS, 32'h0);
    wr(OFS_IFM, 32'h4);
    for (int i = 0; i < 3; i++) begin
      host.pins(ls[i], 1'h0, 1'h0, 6'h15, 3'h2);
      cyc(5);
      rdc("line flag", OFS_FLAGS, 32'h20 >> i);
    end
    wr(OFS_MASKS, 32'h08000108);
    cyc(2);
    check("event ports", ports, 32'h9);
    wr(OFS_STICKY, 32'h1);
    host.pins(LS_J, 1'h0, 1'h1, 6'h15, 3'h2);
    cyc(5);
    host.pins(LS_J, 1'h0, 1'h0, 6'h15, 3'h2);
    cyc(5);
    rdc("sticky held", OFS_FLAGS, 32'h09);
    host.pins(LS_J, 1'h1, 1'h0, 6'h15, 3'h2);
    cyc(5);
    rdc("new packet", OFS_FLAGS, 32'h03);
    host.pins(LS_J, 1'h0, 1'h0, 6'h15, 3'h2);
    cyc(5);
    rdc("rx idle", OFS_FLAGS, 32'h01);
    wr(OFS_FLAGS, 32'h1);
    rdc("cleared", OFS_FLAGS, 32'h0);
    $display("t_flags done");
  endtask

  task automatic t_soft();
    wr(OFS_ADDR, 32'hFFFFFFFF);
    rdc("address", OFS_ADDR, 32'h7F);
    wr(OFS_RESET, 32'hA5A5A5A5);
    rdc("address", OFS_ADDR, 32'h0);
    rdc("func", OFS_FUNC, 32'h7);
    rdc("sticky", OFS_STICKY, 32'h0);
    rdc("endpoint", OFS_ENDP, 32'h0);
    check("serial pins", ser_pins, 32'h2);
    wr(8'h40, 32'hFFFFFFFF);
    rdc("unmapped", 8'h40, 32'h0);
    rdc("unmapped", 8'h3C, 32'h0);
    $display("t_soft done");
  endtask

  initial begin
    cyc(20);
    reset = 1'h0;
    t_reset();
    t_ctrl();
    t_status();
    t_filter();
    t_frame();
    t_flags();
    t_soft();
    stop_test();
  end
endmodule
`default_nettype wire
